// [srwds_defs.vh]
// Constants for the reference window detector and capture block.
// Assumes inclusion by bare name from every design file of the block.
`ifndef SRWDS_DEFS_VH
`define SRWDS_DEFS_VH

// Register indices; byte address is four times the index.
`define SRWDS_IDX_MAP_LOW 10'h02C
`define SRWDS_IDX_MAP_MID 10'h02D
`define SRWDS_IDX_MAP_HIGH 10'h02E
`define SRWDS_IDX_CTRL 10'h030
`define SRWDS_IDX_PERIOD 10'h031
`define SRWDS_IDX_STATUS 10'h032

// Widths.
`define SRWDS_TAPS 24
`define SRWDS_SEL_W 4
`define SRWDS_CNT_W 16
`define SRWDS_EVT_W 8

// Control register fields.
`define SRWDS_CTRL_SEL_LSB 0
`define SRWDS_CTRL_SEL_MSB 3
`define SRWDS_CTRL_FINE 4
`define SRWDS_CTRL_DETECT 5
`define SRWDS_CTRL_CLEAR 6
`define SRWDS_CTRL_MODE 7
`define SRWDS_CTRL_ONESHOT 8
`define SRWDS_CTRL_ARM 9

// Status register fields.
`define SRWDS_STAT_CNT_LSB 0
`define SRWDS_STAT_CNT_MSB 15
`define SRWDS_STAT_EVT_LSB 16
`define SRWDS_STAT_EVT_MSB 23
`define SRWDS_STAT_LEVEL 24
`define SRWDS_STAT_ARMED 25
`define SRWDS_STAT_TRANS 26

// Reset values.
`define SRWDS_SEL_RST 4'h0
`define SRWDS_FINE_RST 1'b1
`define SRWDS_DETECT_RST 1'b1
`define SRWDS_MODE_RST 1'b0
`define SRWDS_ONESHOT_RST 1'b0
`define SRWDS_PERIOD_RST 16'h0020
`define SRWDS_MAP_EDGE_BITS 24'h800001

`endif

// [srwds_detect.v]
// Position detector: one flag per delayed sampling instance of the reference.
// Assumes the tap samples arrive synchronous to pclk, smallest delay at bit 0.
`timescale 1ns/100ps
`include "srwds_defs.vh"

module srwds_detect (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire detect_enable,
  input wire map_clear,
  // Tap samples
  input wire [`SRWDS_TAPS-1:0] tap_samples,
  // Result
  output reg [`SRWDS_TAPS-1:0] position_map_reg
);

  wire [`SRWDS_TAPS-1:0] hit;
  reg [`SRWDS_TAPS-1:0] position_map_next;

  // A tap is at risk when the reference changes between it and a neighbour.
  genvar i;
  generate
    for (i = 0; i < `SRWDS_TAPS; i = i + 1) begin : g_tap
      if (i == 0 || i == `SRWDS_TAPS-1) begin : g_edge
        assign hit[i] = 1'b1; // R6
      end else begin : g_mid
        assign hit[i] = (tap_samples[i-1] != tap_samples[i]) || (tap_samples[i] != tap_samples[i+1]); // R2
      end
    end
  endgenerate

  // Flags are sticky; a new hit in the clearing cycle is kept.
  always @* begin
    position_map_next = map_clear ? `SRWDS_MAP_EDGE_BITS : position_map_reg;
    if (detect_enable) begin
      position_map_next = position_map_next | hit; // R1
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position_map_reg <= `SRWDS_MAP_EDGE_BITS;
    end else begin
      position_map_reg <= position_map_next;
    end
  end

endmodule // srwds_detect

// [srwds_ref_source.sv]
// External reference source: drives the 24 delayed samples of one reference pulse.
// Assumes a fire strobe from the bench and a free-running device clock.
`timescale 1ns/100ps
module srwds_ref_source (
  // Clock
  input wire pclk,
  // Pulse request
  input wire fire,
  input wire [4:0] edge_pos,
  // Delayed samples
  output wire [23:0] tap_samples
);
  reg [2:0] phase_reg = 3'h0;
  always @(posedge pclk) begin
    phase_reg <= fire ? 3'h1 : ((phase_reg != 3'h0 && phase_reg < 3'h5) ? phase_reg + 3'h1 : 3'h0);
  end
  assign tap_samples = (phase_reg == 3'h1) ? (24'hFFFFFF << edge_pos) :
    ((phase_reg != 3'h0) ? 24'hFFFFFF : 24'h000000);
endmodule // srwds_ref_source

// [srwds_top.v]
// Reference window detector, tap selection and multiframe counter reset, with APB registers.
// Assumes an external delay line samples the reference at 24 delayed clock instances,
// synchronous to pclk, spaced coarse or fine by fine_step_enable.
//
// Behaviour
// R1: The reference position within the clock period is measured into a readable map.
// R2: Each map bit is one candidate instance; 1 means at risk, 0 means usable.
// R3: The map holds twenty-four instances ordered from smallest to largest delay.
// R4: The reference is captured with the chosen delayed clock instance.
// R5: Tap select is a map bit index; only indices 0 to 15 are selectable.
// R6: Map bits 0 and 23 always read as 1.
// R7: Step size setting 0 gives coarse steps, 1 gives fine steps.
// R8: Software keeps fine steps unless no transition region shows in the map.
// R9: Software picks the middle of the usable window, preferring low indices.
// R10: Map bits above 15 are informational and never affect capture.
// R11: Clock and reference are applied before software reads the map.
// R12: A captured reference event resets the multiframe or multiblock counter; in one-shot mode only the first event after arming does.
// R13: The reference is a single pulse or a divided multiframe rate clock.
// R14: Setting changes apply to later captures; the chosen tap holds between writes.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`include "srwds_defs.vh"

module srwds_top (
  // APB clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Delay line
  input wire [`SRWDS_TAPS-1:0] tap_samples,
  output wire fine_step_enable,
  // Captured reference and counters
  output reg captured_ref_reg,
  output reg ref_event_reg,
  output reg lmfc_boundary_reg,
  output reg lemc_boundary_reg
);

  // Capture states.
  localparam [2:0] ST_WAIT_LOW = 3'b001;
  localparam [2:0] ST_ARMED = 3'b010;
  localparam [2:0] ST_HIGH = 3'b100;

  // Control and status storage.
  reg [`SRWDS_SEL_W-1:0] capture_tap_select_reg;
  reg fine_step_reg;
  reg detect_enable_reg;
  reg mode_64b_reg;
  reg oneshot_reg;
  reg armed_reg;
  reg armed_next;
  reg [`SRWDS_CNT_W-1:0] period_reg;
  reg [`SRWDS_SEL_W-1:0] active_tap_reg;
  reg [`SRWDS_SEL_W-1:0] active_tap_next;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`SRWDS_CNT_W-1:0] frame_count_reg;
  reg [`SRWDS_CNT_W-1:0] frame_count_next;
  reg [`SRWDS_EVT_W-1:0] event_count_reg;
  reg [`SRWDS_EVT_W-1:0] event_count_next;
  reg [31:0] read_next;
  reg decode_ok;

  wire [`SRWDS_TAPS-1:0] ref_position_map;
  wire [9:0] reg_index;
  wire setup_phase;
  wire access_phase;
  wire wr_ctrl;
  wire wr_period;
  wire map_clear;
  wire tap_change;
  wire selected_sample;
  wire capture_edge;
  wire realign;
  wire transition_seen;
  wire frame_wrap;

  // APB decode.
  assign reg_index = paddr[11:2];
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign pready = 1'b1;

  always @* begin
    case (reg_index)
      `SRWDS_IDX_MAP_LOW,
      `SRWDS_IDX_MAP_MID,
      `SRWDS_IDX_MAP_HIGH: begin
        decode_ok = !pwrite;
      end
      `SRWDS_IDX_CTRL,
      `SRWDS_IDX_PERIOD,
      `SRWDS_IDX_STATUS: begin
        decode_ok = 1'b1;
      end
      default: begin
        decode_ok = 1'b0;
      end
    endcase
  end

  assign pslverr = access_phase && !decode_ok;
  assign wr_ctrl = access_phase && pwrite && (reg_index == `SRWDS_IDX_CTRL);
  assign wr_period = access_phase && pwrite && (reg_index == `SRWDS_IDX_PERIOD);

  // Writes to the control and period registers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_tap_select_reg <= `SRWDS_SEL_RST;
      fine_step_reg <= `SRWDS_FINE_RST;
      detect_enable_reg <= `SRWDS_DETECT_RST;
      mode_64b_reg <= `SRWDS_MODE_RST;
      oneshot_reg <= `SRWDS_ONESHOT_RST;
      period_reg <= `SRWDS_PERIOD_RST;
    end else begin
      if (wr_ctrl) begin
        capture_tap_select_reg <= pwdata[`SRWDS_CTRL_SEL_MSB:`SRWDS_CTRL_SEL_LSB]; // R5
        fine_step_reg <= pwdata[`SRWDS_CTRL_FINE]; // R7
        detect_enable_reg <= pwdata[`SRWDS_CTRL_DETECT];
        mode_64b_reg <= pwdata[`SRWDS_CTRL_MODE];
        oneshot_reg <= pwdata[`SRWDS_CTRL_ONESHOT];
      end
      if (wr_period) begin
        period_reg <= pwdata[`SRWDS_CNT_W-1:0];
      end
    end
  end

  // Step size drives the delay line directly.
  assign fine_step_enable = fine_step_reg; // R7

  // A new step size invalidates the map, as does an explicit clear.
  assign map_clear = wr_ctrl && (pwdata[`SRWDS_CTRL_CLEAR] || (pwdata[`SRWDS_CTRL_FINE] != fine_step_reg));

  srwds_detect u_detect (
    .pclk(pclk),
    .presetn(presetn),
    .detect_enable(detect_enable_reg),
    .map_clear(map_clear),
    .tap_samples(tap_samples),
    .position_map_reg(ref_position_map)
  );

  // Only the low sixteen taps can feed capture; upper map bits are never read here.
  assign selected_sample = tap_samples[{1'b0, active_tap_reg}]; // R4 R10
  assign tap_change = (capture_tap_select_reg != active_tap_reg);

  // Capture sequence: wait for a low reference, then take its rising edge.
  always @* begin
    state_next = state_reg;
    active_tap_next = active_tap_reg;
    case (state_reg)
      ST_WAIT_LOW: begin
        active_tap_next = capture_tap_select_reg; // R14
        if (!captured_ref_reg) begin
          state_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (tap_change) begin
          active_tap_next = capture_tap_select_reg; // R14
          state_next = ST_WAIT_LOW;
        end else if (captured_ref_reg) begin
          state_next = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (!captured_ref_reg) begin
          state_next = ST_WAIT_LOW;
        end
      end
      default: begin
        state_next = ST_WAIT_LOW;
      end
    endcase
  end

  assign capture_edge = (state_reg == ST_ARMED) && !tap_change && captured_ref_reg;

  // One-shot mode realigns only on the first event after arming.
  assign realign = capture_edge && (!oneshot_reg || armed_reg);

  always @* begin
    armed_next = armed_reg;
    if (realign) begin
      armed_next = 1'b0;
    end
    if (wr_ctrl && pwdata[`SRWDS_CTRL_ARM]) begin
      armed_next = 1'b1;
    end
  end

  // Local multiframe or extended multiblock counter.
  assign frame_wrap = (frame_count_reg >= period_reg - 16'h0001);

  always @* begin
    if (realign) begin
      frame_count_next = 16'h0000; // R12
    end else if (frame_wrap) begin
      frame_count_next = 16'h0000;
    end else begin
      frame_count_next = frame_count_reg + 16'h0001;
    end
    event_count_next = event_count_reg;
    if (realign) begin
      event_count_next = event_count_reg + 8'h01;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_WAIT_LOW;
      active_tap_reg <= `SRWDS_SEL_RST;
      captured_ref_reg <= 1'b0;
      ref_event_reg <= 1'b0;
      armed_reg <= 1'b0;
      frame_count_reg <= 16'h0000;
      event_count_reg <= 8'h00;
      lmfc_boundary_reg <= 1'b0;
      lemc_boundary_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      active_tap_reg <= active_tap_next;
      captured_ref_reg <= selected_sample; // R4
      ref_event_reg <= realign;
      armed_reg <= armed_next;
      frame_count_reg <= frame_count_next;
      event_count_reg <= event_count_next;
      lmfc_boundary_reg <= (frame_count_next == 16'h0000) && !mode_64b_reg; // R12
      lemc_boundary_reg <= (frame_count_next == 16'h0000) && mode_64b_reg; // R12
    end
  end

  // Any interior flag shows a transition region in the map.
  assign transition_seen = |(ref_position_map & ~`SRWDS_MAP_EDGE_BITS);

  // Read data, registered in the setup phase.
  always @* begin
    read_next = 32'h00000000;
    case (reg_index)
      `SRWDS_IDX_MAP_LOW: begin
        read_next[7:0] = ref_position_map[7:0]; // R3
      end
      `SRWDS_IDX_MAP_MID: begin
        read_next[7:0] = ref_position_map[15:8]; // R3
      end
      `SRWDS_IDX_MAP_HIGH: begin
        read_next[7:0] = ref_position_map[23:16]; // R3
      end
      `SRWDS_IDX_CTRL: begin
        read_next[`SRWDS_CTRL_SEL_MSB:`SRWDS_CTRL_SEL_LSB] = capture_tap_select_reg;
        read_next[`SRWDS_CTRL_FINE] = fine_step_reg;
        read_next[`SRWDS_CTRL_DETECT] = detect_enable_reg;
        read_next[`SRWDS_CTRL_MODE] = mode_64b_reg;
        read_next[`SRWDS_CTRL_ONESHOT] = oneshot_reg;
      end
      `SRWDS_IDX_PERIOD: begin
        read_next[`SRWDS_CNT_W-1:0] = period_reg;
      end
      `SRWDS_IDX_STATUS: begin
        read_next[`SRWDS_STAT_CNT_MSB:`SRWDS_STAT_CNT_LSB] = frame_count_reg;
        read_next[`SRWDS_STAT_EVT_MSB:`SRWDS_STAT_EVT_LSB] = event_count_reg;
        read_next[`SRWDS_STAT_LEVEL] = captured_ref_reg;
        read_next[`SRWDS_STAT_ARMED] = armed_reg;
        read_next[`SRWDS_STAT_TRANS] = transition_seen;
      end
      default: begin
        read_next = 32'h00000000;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase) begin
      prdata <= read_next;
    end
  end

endmodule // srwds_top

// [srwds_top_monitor.sv]
// Checker for the reference window block, watching only the top ports.
// Assumes binding to srwds_top, one clock domain and an asynchronous active-low reset.
`timescale 1ns/100ps
module srwds_top_monitor (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // Delay line and capture
  input wire [23:0] tap_samples,
  input wire fine_step_enable,
  input wire captured_ref_reg,
  input wire ref_event_reg,
  input wire lmfc_boundary_reg,
  input wire lemc_boundary_reg
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  wire rd = psel && penable && !pwrite;
  wire wr = psel && penable && pwrite;
  a_apb_ready: assert property (s_setup ##1 s_access |-> pready)
    else $error("access phase without ready");
  a_err_idle: assert property (!penable |-> !pslverr)
    else $error("error outside access phase");
  a_map_ro: assert property (wr && paddr inside {12'h0B0, 12'h0B4, 12'h0B8} |-> pslverr)
    else $error("map write not refused");
  a_map_first: assert property (rd && paddr == 12'h0B0 |-> prdata[0])
    else $error("map bit 0 reads 0");
  a_map_last: assert property (rd && paddr == 12'h0B8 |-> prdata[7])
    else $error("map bit 23 reads 0");
  a_fine_follow: assert property (wr && paddr == 12'h0C0 |=> fine_step_enable == $past(pwdata[4]))
    else $error("step size not taken");
  a_cap_high: assert property ($past(presetn) && $past(&tap_samples[15:0]) |-> captured_ref_reg)
    else $error("capture missed high level");
  a_cap_low: assert property ($past(presetn) && $past(tap_samples[15:0]) == 16'h0000 |-> !captured_ref_reg)
    else $error("capture missed low level");
  a_event_pulse: assert property (ref_event_reg |=> !ref_event_reg)
    else $error("event longer than one cycle");
  a_event_bound: assert property (ref_event_reg |-> lmfc_boundary_reg ^ lemc_boundary_reg)
    else $error("event without one boundary");
  a_event_cause: assert property (ref_event_reg |-> $past(captured_ref_reg) && !$past(captured_ref_reg, 2))
    else $error("event without captured rise");
endmodule // srwds_top_monitor

bind srwds_top srwds_top_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .tap_samples, .fine_step_enable, .captured_ref_reg, .ref_event_reg,
  .lmfc_boundary_reg, .lemc_boundary_reg);

// [testbench.sv]
// Self-checking bench for the reference window block over APB.
// Assumes srwds_top, the reference source model and the bound checker.
`timescale 1ns/100ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic fire = 1'b0;
  logic [4:0] edge_pos = 5'h00;
  wire pready, pslverr, fine_step_enable, captured_ref_reg, ref_event_reg, lmfc_boundary_reg, lemc_boundary_reg;
  wire [31:0] prdata;
  wire [23:0] tap_samples;
  logic [31:0] rdata;
  logic rerr;
  logic [1:0] bound_seen = 2'b00;
  int errors = 0;
  int total_checks = 0;
  int bound_count = 0;
  int bound_mark = 0;
  typedef struct {logic [4:0] pos; logic [3:0] sel; logic mode; logic [23:0] map;} srwds_row_t;
  srwds_row_t rows [4] = '{'{5'd1, 4'd8, 1'b0, 24'h800003}, '{5'd5, 4'd8, 1'b1, 24'h800031},
    '{5'd12, 4'd4, 1'b0, 24'h801801}, '{5'd20, 4'd15, 1'b1, 24'h980001}};
  srwds_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .tap_samples, .fine_step_enable, .captured_ref_reg, .ref_event_reg, .lmfc_boundary_reg, .lemc_boundary_reg);
  srwds_ref_source u_src (.pclk, .fire, .edge_pos, .tap_samples);
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (ref_event_reg === 1'b1) bound_seen <= {lemc_boundary_reg, lmfc_boundary_reg};
    if ((lmfc_boundary_reg | lemc_boundary_reg) === 1'b1) bound_count <= bound_count + 1;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task pulse(input logic [4:0] p);
    edge_pos <= p;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    apb(a, 1'b0, 32'h00000000);
    chk(rdata, exp);
    chk({31'h0, rerr}, {31'h0, eexp});
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(12'h0C0, 1'b1, {24'h0, rows[i].mode, 3'b111, rows[i].sel});
      pulse(rows[i].pos);
      rd_chk(12'h0B0, {24'h0, rows[i].map[7:0]}, 1'b0);
      rd_chk(12'h0B4, {24'h0, rows[i].map[15:8]}, 1'b0);
      rd_chk(12'h0B8, {24'h0, rows[i].map[23:16]}, 1'b0);
      apb(12'h0C8, 1'b0, 32'h00000000);
      chk({24'h0, rdata[23:16]}, 32'(i + 1));
      chk({31'h0, rdata[26]}, 32'h1);
      chk({30'h0, bound_seen}, rows[i].mode ? 32'h2 : 32'h1);
    end
    apb(12'h0B4, 1'b1, 32'h000000FF);
    chk({31'h0, rerr}, 32'h1);
    rd_chk(12'h0B4, {24'h0, rows[3].map[15:8]}, 1'b0);
    rd_chk(12'hFFC, 32'h00000000, 1'b1);
    apb(12'h0C0, 1'b1, 32'h00000020);
    chk({31'h0, fine_step_enable}, 32'h0);
    rd_chk(12'h0B0, 32'h00000001, 1'b0);
    rd_chk(12'h0B8, 32'h00000080, 1'b0);
    apb(12'h0C0, 1'b1, 32'h00000040);
    pulse(5'd10);
    apb(12'h0C8, 1'b0, 32'h00000000);
    chk(rdata, 32'h00050005);
    rd_chk(12'h0B4, 32'h00000000, 1'b0);
    apb(12'h0C0, 1'b1, 32'h00000320);
    apb(12'h0C8, 1'b0, 32'h00000000);
    chk({31'h0, rdata[25]}, 32'h1);
    pulse(5'd10);
    pulse(5'd10);
    apb(12'h0C8, 1'b0, 32'h00000000);
    chk(rdata, 32'h0406000E);
    rd_chk(12'h0B4, 32'h00000006, 1'b0);
    apb(12'h0C4, 1'b1, 32'h00000008);
    bound_mark = bound_count;
    repeat (64) @(posedge pclk);
    chk(32'(bound_count - bound_mark), 32'h8);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h0C0, 32'h00000030, 1'b0);
    chk({31'h0, fine_step_enable}, 32'h1);
    rd_chk(12'h0C4, 32'h00000020, 1'b0);
    rd_chk(12'h0B4, 32'h00000000, 1'b0);
    give_verdict();
  end
endmodule // testbench
